// *** design/gdsi_pkg.sv ***
// Constants, register map and state type for the guard door speed interlock
package gdsi_pkg;

	// ----------------------------------------------------------------
	// Clock and time base
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 40_000_000;
	localparam int TICK_US = 1000;
	localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
	localparam int CHECK_DELAY_MS = 7300;
	localparam int STOP_TIMEOUT_MS = 2000;
	localparam int DISAGREE_MS = 50;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int SPEED_W = 16;
	localparam int TIMER_W = 16;
	localparam int PRE_W = 16;
	localparam int DIS_W = 8;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_SPEED_LIMIT = 8'h04;
	localparam logic [7:0] OFS_STANDSTILL = 8'h08;
	localparam logic [7:0] OFS_CHECK_DELAY = 8'h0C;
	localparam logic [7:0] OFS_STOP_TIMEOUT = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_SPEED = 8'h18;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int CTRL_AUTO_BIT = 0;
	localparam int CTRL_STOP_BIT = 1;
	localparam logic CTRL_AUTO_RST = 1'b1;
	localparam logic [SPEED_W-1:0] SPEED_LIMIT_RST = 16'h0100;
	localparam logic [SPEED_W-1:0] STANDSTILL_RST = 16'h0008;
	localparam logic [TIMER_W-1:0] CHECK_DELAY_RST = TIMER_W'(CHECK_DELAY_MS);
	localparam logic [TIMER_W-1:0] STOP_TIMEOUT_RST = TIMER_W'(STOP_TIMEOUT_MS);
	localparam logic [DIS_W-1:0] DISAGREE_TICKS = DIS_W'(DISAGREE_MS);

	// ----------------------------------------------------------------
	// Sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_RUN,
		ST_LS_WAIT,
		ST_LS_MON,
		ST_LOCK_WAIT,
		ST_STOP,
		ST_TQ_OFF
	} gdsi_state_e;

endpackage : gdsi_pkg

// *** design/gdsi_interlock.sv ***
// Guard door unlock, limited speed and stop sequencer with APB registers
//
// Summary of operation
// R01 - Key held in limited-speed position is a level request; key removal ends it.
// R02 - Accept request only without safe-motion fault; request must stay high throughout.
// R03 - Accepted request tells motion application to reduce speed below active limit.
// R04 - Speed monitoring starts after programmable check delay, 7.3 s by default.
// R05 - Motion application brings and keeps speed below limit before delay expiry.
// R06 - After delay, speed below limit asserts door unlock.
// R07 - Speed not below limit after delay sets violation flag.
// R08 - Violation flag holds until limited-speed function is reset.
// R09 - Automatic restart resets limited-speed function on request drop without fault.
// R10 - Limit exceeded after delay requests controlled stop, then torque-off at standstill.
// R11 - Controlled stop reaching standstill issues torque-off.
// R12 - After delay-expiry stop, unlock once torque off and below standstill.
// R13 - Door unlocked or open outside limited-speed or stop mode asserts torque-off.
// R14 - Removing request after normal limited-speed operation issues door lock request.
// R15 - Recovery: close door, drop request, reset locks; falling edge releases torque-off.
// R16 - No motor start until door closed and door locked both asserted.
// R17 - After closing, motion stays blocked until locked and manual reset given.
// R18 - Operator controlled stop allows unlock at standstill with torque-off active.
// R19 - Uncommanded unlock or opening, or any safety fault, executes controlled stop.
// R20 - During stop check deceleration via speed feedback; torque-off at standstill.
// R21 - Motor reset blocked until safe running condition confirmed.
// R22 - Door closed and locked status read on two redundant channels.
// R23 - Any detected malfunction triggers controlled stop then torque-off.
// R24 - Persistent disagreement between door channels is a fault causing controlled stop.
`timescale 1ns/1ps

module gdsi_interlock
	import gdsi_pkg::*;
#(
	parameter int TICK_CYC = TICK_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic limited_speed_req,
	input wire logic [SPEED_W-1:0] speed,
	input wire logic door_closed_ch0,
	input wire logic door_closed_ch1,
	input wire logic door_locked_ch0,
	input wire logic door_locked_ch1,
	input wire logic safety_reset,
	input wire logic drive_fault,
	output logic door_unlock,
	output logic speed_reduce,
	output logic controlled_stop,
	output logic torque_off
);

	// ----------------------------------------------------------------
	// Registers and state
	// ----------------------------------------------------------------
	gdsi_state_e state_q;
	gdsi_state_e state_d;
	logic auto_q;
	logic [SPEED_W-1:0] limit_q;
	logic [SPEED_W-1:0] standstill_q;
	logic [TIMER_W-1:0] delay_q;
	logic [TIMER_W-1:0] stop_to_q;
	logic [PRE_W-1:0] pre_q;
	logic [TIMER_W-1:0] timer_q;
	logic [TIMER_W-1:0] timer_d;
	logic [SPEED_W-1:0] prev_speed_q;
	logic [DIS_W-1:0] dis_cnt_q;
	logic disagree_fault_q;
	logic ramp_fault_q;
	logic ramp_fault_d;
	logic viol_q;
	logic viol_d;
	logic cause_fault_q;
	logic cause_fault_d;
	logic lock_pending_q;
	logic lock_pending_d;
	logic rst_prev_q;
	logic door_unlock_q;
	logic speed_reduce_q;
	logic stop_q;
	logic torque_off_q;
	logic [31:0] prdata_q;
	logic pslverr_q;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	wire logic acc = psel & penable;
	wire logic wr = acc & pwrite;
	wire logic hit_ctrl = paddr == OFS_CTRL;
	wire logic hit_limit = paddr == OFS_SPEED_LIMIT;
	wire logic hit_still = paddr == OFS_STANDSTILL;
	wire logic hit_delay = paddr == OFS_CHECK_DELAY;
	wire logic hit_stopto = paddr == OFS_STOP_TIMEOUT;
	wire logic hit_status = paddr == OFS_STATUS;
	wire logic hit_speed = paddr == OFS_SPEED;
	wire logic hit_rw = hit_ctrl | hit_limit | hit_still | hit_delay | hit_stopto;
	wire logic hit_any = hit_rw | hit_status | hit_speed;
	wire logic bad_acc = setup_err(psel, penable, pwrite, hit_rw, hit_any);
	wire logic sw_stop = wr & hit_ctrl & pwdata[CTRL_STOP_BIT];

	function automatic logic setup_err(input logic s, input logic e, input logic w, input logic rw, input logic any);
		setup_err = s & ~e & (~any | (w & ~rw));
	endfunction : setup_err

	// ----------------------------------------------------------------
	// Door channels and speed compares
	// ----------------------------------------------------------------
	wire logic door_closed = door_closed_ch0 & door_closed_ch1; // R22
	wire logic door_locked = door_locked_ch0 & door_locked_ch1; // R22
	wire logic door_ok = door_closed & door_locked; // R16
	wire logic door_bad = ~door_ok;
	wire logic disagree = (door_closed_ch0 ^ door_closed_ch1) | (door_locked_ch0 ^ door_locked_ch1); // R24
	wire logic any_fault = drive_fault | disagree_fault_q | ramp_fault_q; // R23
	wire logic below_limit = speed < limit_q;
	wire logic at_still = speed < standstill_q;
	wire logic rst_fall = rst_prev_q & ~safety_reset; // R15
	wire logic tick = pre_q == PRE_W'(TICK_CYC - 1);
	wire logic timer_done = timer_q == '0;
	wire logic ramp_bad = tick & (speed > prev_speed_q); // R20
	wire logic restart_ok = door_ok & ~limited_speed_req & ~drive_fault & ~disagree; // R21
	wire logic ls_mode_d = (state_d == ST_LS_WAIT) | (state_d == ST_LS_MON) | (state_d == ST_LOCK_WAIT);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		viol_d = viol_q;
		ramp_fault_d = ramp_fault_q;
		cause_fault_d = cause_fault_q;
		case (state_q)
			ST_RUN: begin
				cause_fault_d = 1'b0;
				if (any_fault || door_bad) begin
					state_d = ST_STOP; // R19
					cause_fault_d = 1'b1;
				end else if (sw_stop) begin
					state_d = ST_STOP; // R18
				end else if (limited_speed_req && !viol_q) begin
					state_d = ST_LS_WAIT; // R01 R02 R03
				end
			end
			ST_LS_WAIT: begin
				if (any_fault || door_bad) begin
					state_d = ST_STOP; // R19
					cause_fault_d = 1'b1;
				end else if (!limited_speed_req) begin
					state_d = ST_LOCK_WAIT; // R02
				end else if (timer_done && below_limit) begin
					state_d = ST_LS_MON; // R04
				end else if (timer_done) begin
					state_d = ST_STOP; // R10
					viol_d = 1'b1; // R07
				end
			end
			ST_LS_MON: begin
				if (any_fault) begin
					state_d = ST_STOP; // R23
					cause_fault_d = 1'b1;
				end else if (!below_limit) begin
					state_d = ST_STOP; // R10
					viol_d = 1'b1; // R07
				end else if (!limited_speed_req) begin
					state_d = ST_LOCK_WAIT; // R14
				end
			end
			ST_LOCK_WAIT: begin
				if (any_fault) begin
					state_d = ST_STOP; // R23
					cause_fault_d = 1'b1;
				end else if (!below_limit) begin
					state_d = ST_STOP; // R10
					viol_d = 1'b1; // R07
				end else if (limited_speed_req && door_ok) begin
					state_d = ST_LS_WAIT;
				end else if (door_ok && (auto_q || rst_fall)) begin
					state_d = ST_RUN; // R09 R16 R17
				end
			end
			ST_STOP: begin
				if (ramp_bad || timer_done) begin
					state_d = ST_TQ_OFF; // R20
					ramp_fault_d = 1'b1;
					cause_fault_d = 1'b1;
				end else if (at_still) begin
					state_d = ST_TQ_OFF; // R11
				end
			end
			ST_TQ_OFF: begin
				if (lock_pending_q && rst_fall && restart_ok) begin
					state_d = ST_RUN; // R15 R17 R21
					viol_d = 1'b0;
					ramp_fault_d = 1'b0;
				end
			end
			default: begin
				state_d = ST_STOP;
				cause_fault_d = 1'b1;
			end
		endcase
		if (!limited_speed_req && ls_mode_d && !any_fault && !viol_q) begin
			viol_d = 1'b0; // R09
		end
	end

	// ----------------------------------------------------------------
	// Timer load and reset press tracking
	// ----------------------------------------------------------------
	always_comb begin
		timer_d = timer_q;
		if (state_d != state_q && state_d == ST_LS_WAIT) begin
			timer_d = delay_q; // R04
		end else if (state_d != state_q && state_d == ST_STOP) begin
			timer_d = stop_to_q;
		end else if (tick && !timer_done) begin
			timer_d = timer_q - TIMER_W'(1);
		end
	end

	assign lock_pending_d = (state_q == ST_TQ_OFF) & (state_d == ST_TQ_OFF) & (lock_pending_q | safety_reset); // R15

	// ----------------------------------------------------------------
	// Sequencer registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_TQ_OFF;
			timer_q <= '0;
			viol_q <= 1'b0;
			ramp_fault_q <= 1'b0;
			cause_fault_q <= 1'b1;
			lock_pending_q <= 1'b0;
			rst_prev_q <= 1'b0;
		end else begin
			state_q <= state_d;
			timer_q <= timer_d;
			viol_q <= viol_d; // R08
			ramp_fault_q <= ramp_fault_d;
			cause_fault_q <= cause_fault_d;
			lock_pending_q <= lock_pending_d;
			rst_prev_q <= safety_reset;
		end
	end

	// ----------------------------------------------------------------
	// Millisecond tick, ramp sample, channel disagreement
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_q <= '0;
			prev_speed_q <= '0;
		end else begin
			pre_q <= tick ? '0 : pre_q + PRE_W'(1);
			if (state_q != ST_STOP || tick) begin
				prev_speed_q <= speed; // R20
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dis_cnt_q <= '0;
			disagree_fault_q <= 1'b0;
		end else begin
			if (!disagree) begin
				dis_cnt_q <= '0;
			end else if (tick && dis_cnt_q != DISAGREE_TICKS) begin
				dis_cnt_q <= dis_cnt_q + DIS_W'(1);
			end
			if (disagree && dis_cnt_q == DISAGREE_TICKS) begin
				disagree_fault_q <= 1'b1; // R24
			end else if (state_d == ST_RUN && state_q == ST_TQ_OFF) begin
				disagree_fault_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Outputs to door, motion application and drive
	// ----------------------------------------------------------------
	wire logic unlock_d = (state_d == ST_LS_MON) // R06
		| ((state_d == ST_TQ_OFF) & ~cause_fault_d & at_still & ~lock_pending_d); // R12 R18
	wire logic tq_off_d = (state_d == ST_TQ_OFF) // R11
		| (door_bad & ~ls_mode_d & (state_d != ST_STOP)); // R13

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			door_unlock_q <= 1'b0;
			speed_reduce_q <= 1'b0;
			stop_q <= 1'b0;
			torque_off_q <= 1'b1;
		end else begin
			door_unlock_q <= unlock_d;
			speed_reduce_q <= ls_mode_d; // R03
			stop_q <= state_d == ST_STOP; // R10 R19
			torque_off_q <= tq_off_d;
		end
	end

	assign door_unlock = door_unlock_q;
	assign speed_reduce = speed_reduce_q;
	assign controlled_stop = stop_q;
	assign torque_off = torque_off_q;

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			auto_q <= CTRL_AUTO_RST;
			limit_q <= SPEED_LIMIT_RST;
			standstill_q <= STANDSTILL_RST;
			delay_q <= CHECK_DELAY_RST;
			stop_to_q <= STOP_TIMEOUT_RST;
		end else if (wr) begin
			if (hit_ctrl) begin
				auto_q <= pwdata[CTRL_AUTO_BIT];
			end
			if (hit_limit) begin
				limit_q <= pwdata[SPEED_W-1:0];
			end
			if (hit_still) begin
				standstill_q <= pwdata[SPEED_W-1:0];
			end
			if (hit_delay) begin
				delay_q <= pwdata[TIMER_W-1:0];
			end
			if (hit_stopto) begin
				stop_to_q <= pwdata[TIMER_W-1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Read data, captured in the setup cycle
	// ----------------------------------------------------------------
	wire logic [31:0] status_word = {20'h00000, torque_off_q, stop_q, speed_reduce_q, door_unlock_q,
		door_ok, drive_fault, ramp_fault_q, disagree_fault_q, viol_q, state_q};
	wire logic [31:0] rd_mux =
		hit_ctrl ? {30'h00000000, 1'b0, auto_q} :
		hit_limit ? {16'h0000, limit_q} :
		hit_still ? {16'h0000, standstill_q} :
		hit_delay ? {16'h0000, delay_q} :
		hit_stopto ? {16'h0000, stop_to_q} :
		hit_status ? status_word :
		hit_speed ? {16'h0000, speed} : 32'h00000000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h00000000;
			pslverr_q <= 1'b0;
		end else if (psel && !penable) begin
			prdata_q <= pwrite ? 32'h00000000 : rd_mux;
			pslverr_q <= bad_acc;
		end
	end

	assign prdata = prdata_q;
	assign pready = 1'b1;
	assign pslverr = pslverr_q & acc;

endmodule : gdsi_interlock

// *** tb/gdsi_interlock_monitor.sv ***
// Port checker for the guard door speed interlock
`timescale 1ns/1ps
module gdsi_interlock_monitor
	import gdsi_pkg::*;
#(
	parameter int TICK_CYC = TICK_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic limited_speed_req,
	input wire logic [SPEED_W-1:0] speed,
	input wire logic door_closed_ch0,
	input wire logic door_closed_ch1,
	input wire logic door_locked_ch0,
	input wire logic door_locked_ch1,
	input wire logic safety_reset,
	input wire logic drive_fault,
	input wire logic door_unlock,
	input wire logic speed_reduce,
	input wire logic controlled_stop,
	input wire logic torque_off
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic door_ok = door_closed_ch0 & door_closed_ch1 & door_locked_ch0 & door_locked_ch1;
	wire logic idle = !speed_reduce && !controlled_stop && !torque_off;
	sequence ls_exit;
		limited_speed_req && door_unlock && !torque_off ##1 !limited_speed_req;
	endsequence
	sequence reset_pulse;
		safety_reset ##1 !safety_reset;
	endsequence
	req_accept_a: assert property (idle && door_ok && !drive_fault && $rose(limited_speed_req) |-> ##[1:2] speed_reduce)
		else $error("speed reduce missing after request");
	lock_req_a: assert property (ls_exit |-> ##[1:2] !door_unlock)
		else $error("door not locked after request removal");
	door_stop_a: assert property (idle && !door_ok |-> ##[1:2] controlled_stop)
		else $error("no stop on bad door");
	fault_stop_a: assert property (idle && drive_fault |-> ##[1:2] controlled_stop)
		else $error("no stop on fault");
	standstill_off_a: assert property (controlled_stop && speed < STANDSTILL_RST |-> ##[1:2] torque_off)
		else $error("no torque off at standstill");
	stop_first_a: assert property ($rose(torque_off) |-> $past(controlled_stop))
		else $error("torque off without stop");
	unlock_slow_a: assert property ($rose(door_unlock) && !torque_off |-> $past(speed) < SPEED_LIMIT_RST)
		else $error("unlock above speed limit");
	unlock_still_a: assert property ($rose(door_unlock) && torque_off |-> $past(speed) < STANDSTILL_RST)
		else $error("unlock above standstill");
	release_a: assert property ($fell(torque_off) |-> door_ok && !limited_speed_req
		&& ($past(safety_reset, 2) || $past(safety_reset, 3)))
		else $error("torque released without reset");
	reset_lock_a: assert property (safety_reset && torque_off |-> ##[1:2] !door_unlock)
		else $error("reset press did not lock");
	cover property (reset_pulse ##[1:3] $fell(torque_off));
endmodule : gdsi_interlock_monitor

// *** tb/gdsi_plant.sv ***
// Model of door switch, door lock and drive
`timescale 1ns/1ps
module gdsi_plant
	import gdsi_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic door_unlock,
	input wire logic speed_reduce,
	input wire logic controlled_stop,
	input wire logic torque_off,
	input wire logic open_cmd,
	input wire logic obey,
	input wire logic ch1_open,
	output logic [SPEED_W-1:0] speed,
	output logic door_closed_ch0,
	output logic door_closed_ch1,
	output logic door_locked_ch0,
	output logic door_locked_ch1
);
	logic [SPEED_W-1:0] target;
	logic locked_q;
	assign target = (torque_off | controlled_stop) ? 16'h0000 : (speed_reduce & obey) ? 16'h0040 : 16'h0200;
	assign door_closed_ch0 = !open_cmd;
	assign door_closed_ch1 = !open_cmd && !ch1_open;
	assign door_locked_ch0 = locked_q;
	assign door_locked_ch1 = locked_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			speed <= 16'h0000;
			locked_q <= 1'b0;
		end else begin
			if (speed > target + 16'h0004) speed <= speed - 16'h0004;
			else if (speed + 16'h0004 < target) speed <= speed + 16'h0004;
			else speed <= target;
			locked_q <= !open_cmd && !door_unlock;
		end
	end
endmodule : gdsi_plant

// *** tb/gdsi_interlock_tb.sv ***
// Self-checking bench for the guard door speed interlock
`timescale 1ns/1ps
module gdsi_interlock_tb
	import gdsi_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, req, rst_btn, fault, open_cmd, obey, err, skew;
	logic [7:0] paddr;
	logic [31:0] pwdata, rd, prdata;
	logic pready, pslverr, door_unlock, speed_reduce, controlled_stop, torque_off;
	logic dc0, dc1, dl0, dl1;
	logic [SPEED_W-1:0] speed;
	logic [3:0] outs;
	int bad_count, n_compared;
	assign outs = {door_unlock, speed_reduce, controlled_stop, torque_off};
	gdsi_interlock #(.TICK_CYC(4)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.limited_speed_req(req), .speed(speed), .door_closed_ch0(dc0), .door_closed_ch1(dc1),
		.door_locked_ch0(dl0), .door_locked_ch1(dl1), .safety_reset(rst_btn), .drive_fault(fault),
		.door_unlock(door_unlock), .speed_reduce(speed_reduce), .controlled_stop(controlled_stop),
		.torque_off(torque_off));
	gdsi_plant plant_u (.pclk(pclk), .presetn(presetn), .door_unlock(door_unlock), .speed_reduce(speed_reduce),
		.controlled_stop(controlled_stop), .torque_off(torque_off), .open_cmd(open_cmd), .obey(obey), .ch1_open(skew),
		.speed(speed), .door_closed_ch0(dc0), .door_closed_ch1(dc1), .door_locked_ch0(dl0), .door_locked_ch1(dl1));
	initial begin
		pclk = 0;
		forever #12.5 pclk = ~pclk;
	end
	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : test_done
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(0, a, 0);
		chk(nm, e, rd & m);
	endtask : rdchk
	task automatic wait_out(input string nm, input int i, input logic v, input int n);
		int k;
		k = 0;
		#1;
		while (outs[i] !== v && k < n) begin
			@(posedge pclk);
			#1;
			k++;
		end
		chk(nm, 32'(v), 32'(outs[i]));
		@(posedge pclk);
	endtask : wait_out
	task automatic recover();
		@(posedge pclk);
		req <= 0;
		open_cmd <= 0;
		fault <= 0;
		obey <= 1;
		repeat (3) @(posedge pclk);
		rst_btn <= 1;
		repeat (4) @(posedge pclk);
		wait_out("unlock on reset", 3, 0, 1);
		rst_btn <= 0;
		wait_out("torque off", 0, 0, 6);
	endtask : recover
	task automatic t_boot();
		wait_out("torque off", 0, 1, 1);
		rdchk("ctrl", OFS_CTRL, 32'hFFFFFFFF, 32'h00000001);
		chk("ctrl err", 32'h0, 32'(err));
		rdchk("limit", OFS_SPEED_LIMIT, 32'hFFFFFFFF, 32'h00000100);
		rdchk("delay", OFS_CHECK_DELAY, 32'hFFFFFFFF, 32'h00001C84);
		rdchk("unmapped", 8'h1C, 32'hFFFFFFFF, 32'h00000000);
		chk("unmapped err", 32'h1, 32'(err));
		apb(1, OFS_STATUS, 32'h00000000);
		chk("ro err", 32'h1, 32'(err));
		apb(1, OFS_CHECK_DELAY, 32'h00000032);
		rdchk("delay", OFS_CHECK_DELAY, 32'hFFFFFFFF, 32'h00000032);
		recover();
	endtask : t_boot
	task automatic t_ls_ok();
		repeat (150) @(posedge pclk);
		req <= 1;
		wait_out("reduce", 2, 1, 3);
		repeat (150) @(posedge pclk);
		wait_out("early unlock", 3, 0, 1);
		wait_out("unlock", 3, 1, 80);
		rdchk("flag", OFS_STATUS, 32'h00000008, 32'h00000000);
		req <= 0;
		wait_out("lock", 3, 0, 3);
		wait_out("restart", 2, 0, 6);
	endtask : t_ls_ok
	task automatic t_manual();
		apb(1, OFS_CTRL, 32'h00000000);
		req <= 1;
		wait_out("unlock", 3, 1, 220);
		req <= 0;
		wait_out("lock", 3, 0, 3);
		repeat (8) @(posedge pclk);
		wait_out("held in lock wait", 2, 1, 1);
		rst_btn <= 1;
		repeat (2) @(posedge pclk);
		rst_btn <= 0;
		wait_out("manual restart", 2, 0, 4);
		apb(1, OFS_CTRL, 32'h00000001);
	endtask : t_manual
	task automatic t_skew();
		repeat (150) @(posedge pclk);
		skew <= 1;
		wait_out("stop", 1, 1, 4);
		repeat (240) @(posedge pclk);
		rdchk("disagree", OFS_STATUS, 32'h00000010, 32'h00000010);
		rst_btn <= 1;
		repeat (4) @(posedge pclk);
		rst_btn <= 0;
		repeat (4) @(posedge pclk);
		wait_out("refused restart", 0, 1, 1);
		skew <= 0;
		recover();
		rdchk("disagree clear", OFS_STATUS, 32'h00000010, 32'h00000000);
	endtask : t_skew
	task automatic t_ls_bad();
		obey <= 0;
		req <= 1;
		wait_out("stop", 1, 1, 220);
		rdchk("flag", OFS_STATUS, 32'h00000008, 32'h00000008);
		wait_out("torque off", 0, 1, 200);
		wait_out("unlock", 3, 1, 4);
		rdchk("flag held", OFS_STATUS, 32'h00000008, 32'h00000008);
		recover();
		rdchk("flag clear", OFS_STATUS, 32'h00000008, 32'h00000000);
	endtask : t_ls_bad
	task automatic t_op_stop();
		repeat (150) @(posedge pclk);
		apb(1, OFS_CTRL, 32'h00000003);
		wait_out("stop", 1, 1, 4);
		wait_out("torque off", 0, 1, 200);
		wait_out("unlock", 3, 1, 4);
		rdchk("ctrl", OFS_CTRL, 32'hFFFFFFFF, 32'h00000001);
		recover();
	endtask : t_op_stop
	task automatic t_door();
		repeat (150) @(posedge pclk);
		open_cmd <= 1;
		wait_out("stop", 1, 1, 4);
		wait_out("torque off", 0, 1, 200);
		wait_out("no unlock", 3, 0, 1);
		wait_out("open door torque", 0, 1, 1);
		recover();
		fault <= 1;
		wait_out("stop", 1, 1, 4);
		wait_out("torque off", 0, 1, 200);
		recover();
	endtask : t_door
	initial begin
		repeat (20000) @(posedge pclk);
		bad_count++;
		test_done();
	end
	initial begin
		presetn = 0;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		req = 0;
		rst_btn = 0;
		fault = 0;
		open_cmd = 0;
		obey = 1;
		skew = 0;
		bad_count = 0;
		n_compared = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1;
		t_boot();
		t_ls_ok();
		t_manual();
		t_ls_bad();
		t_op_stop();
		t_door();
		t_skew();
		test_done();
	end
endmodule : gdsi_interlock_tb
bind gdsi_interlock gdsi_interlock_monitor #(.TICK_CYC(TICK_CYC)) mon_u (.pclk(pclk), .presetn(presetn),
	.limited_speed_req(limited_speed_req), .speed(speed), .door_closed_ch0(door_closed_ch0),
	.door_closed_ch1(door_closed_ch1), .door_locked_ch0(door_locked_ch0), .door_locked_ch1(door_locked_ch1),
	.safety_reset(safety_reset), .drive_fault(drive_fault), .door_unlock(door_unlock),
	.speed_reduce(speed_reduce), .controlled_stop(controlled_stop), .torque_off(torque_off));
